// ===== design/spsr_regs.sv
// Purpose: Shared-address pointer readback and one-shot command strobes
// Assumes: Host read/write strobes on i_clk, one cycle each
// Notes: Engines acting on the strobes sit outside this block
// Notes on behaviour
// RL1 - Read returns stack pointer outside enhanced BC
// RL2 - Enhanced BC read returns instruction list pointer
// RL3 - Readback is 16-bit, read-only, zero after reset
// RL4 - Host writes zero to reserved bits
// RL5 - Offline RT restarts after self-test completes
// RL6 - Bit 11 brings offline RT online
// RL7 - Bit 10 clears self-test result register
// RL8 - Bit 9 launches RAM self-test
// RL9 - Bit 7 launches protocol self-test
// RL10 - Bit 6 halts BC or stops monitor
// RL11 - Bit 5 halts BC at frame end
// RL12 - Bit 4 steps tag only at 110
// RL13 - Bit 3 clears time tag counter
// RL14 - Bit 2 clears both interrupt status registers
// RL15 - Bit 1 starts BC or monitor
// RL16 - Bit 0 triggers software reset
// RL17 - Resolution 111 steps tag on external clock
// RL18 - Read-clear off: only bit 2 clears
// RL19 - Commands are one-cycle pulses, zero ignored
// RL20 - Reads and writes of shared address independent
`timescale 1ns/1ps
module spsr_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  input wire logic [1:0] i_mode,
  input wire logic i_enhanced_bc,
  input wire logic [15:0] i_stack_ptr,
  input wire logic [15:0] i_instr_ptr,
  input wire logic [2:0] i_tag_res,
  input wire logic i_irq_read_clear,
  input wire logic i_offline_on_selftest,
  input wire logic i_selftest_done,
  input wire logic i_tag_clk,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_soft_reset_cmd,
  output logic o_controller_monitor_go,
  output logic o_irq_status_clear,
  output logic o_tag_counter_clear,
  output logic o_tag_counter_step,
  output logic o_halt_end_of_frame,
  output logic o_halt_end_of_message,
  output logic o_monitor_stop,
  output logic o_protocol_selftest_go,
  output logic o_ram_selftest_go,
  output logic o_clear_selftest_result,
  output logic o_terminal_back_online,
  output logic o_rt_offline
);
  logic wr_hit;
  logic rd_hit;
  logic is_bc;
  logic is_mt;
  logic tag_clk_lvl;
  logic tag_clk_rise;
  logic [15:0] cmd;
  logic rt_st_cmd_r;

  assign wr_hit = i_wr && (i_addr == spsr_pkg::SHARED_OFFSET); // RL20
  assign rd_hit = i_rd && (i_addr == spsr_pkg::SHARED_OFFSET); // RL20
  assign is_bc = (i_mode == spsr_pkg::MODE_BC);
  assign is_mt = (i_mode == spsr_pkg::MODE_MT);
  assign cmd = wr_hit ? i_wdata : 16'h0000;

  spsr_sync u_tag_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_tag_clk),
    .o_level(tag_clk_lvl),
    .o_rise(tag_clk_rise)
  );

  // Pointer readback
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= spsr_pkg::PTR_RESET; // RL3
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= rd_hit;
      if (rd_hit) begin
        if (is_bc && i_enhanced_bc) begin
          o_rdata <= i_instr_ptr; // RL2
        end else begin
          o_rdata <= i_stack_ptr; // RL1
        end
      end
    end
  end

  // One-shot strobes; zero bits and reserved bits do nothing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_soft_reset_cmd <= 1'b0;
      o_controller_monitor_go <= 1'b0;
      o_irq_status_clear <= 1'b0;
      o_tag_counter_clear <= 1'b0;
      o_halt_end_of_frame <= 1'b0;
      o_halt_end_of_message <= 1'b0;
      o_monitor_stop <= 1'b0;
      o_protocol_selftest_go <= 1'b0;
      o_ram_selftest_go <= 1'b0;
      o_clear_selftest_result <= 1'b0;
    end else begin
      o_soft_reset_cmd <= cmd[spsr_pkg::B_SOFT_RESET]; // RL16 RL19
      o_controller_monitor_go <=
        cmd[spsr_pkg::B_CTRL_MON_GO] & (is_bc | is_mt); // RL15
      o_irq_status_clear <= cmd[spsr_pkg::B_IRQ_CLEAR]; // RL14 RL18
      o_tag_counter_clear <= cmd[spsr_pkg::B_TAG_CLEAR]; // RL13
      o_halt_end_of_frame <= cmd[spsr_pkg::B_HALT_FRAME] & is_bc; // RL11
      o_halt_end_of_message <= cmd[spsr_pkg::B_HALT_MSG] & is_bc; // RL10
      o_monitor_stop <= cmd[spsr_pkg::B_HALT_MSG] & is_mt; // RL10
      o_protocol_selftest_go <= cmd[spsr_pkg::B_PROTO_TEST]; // RL9
      o_ram_selftest_go <= cmd[spsr_pkg::B_RAM_TEST]; // RL8
      o_clear_selftest_result <= cmd[spsr_pkg::B_CLR_RESULT]; // RL7
    end
  end

  // Time tag step: by command at 110, by external clock at 111
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tag_counter_step <= 1'b0;
    end else begin
      o_tag_counter_step <=
        (cmd[spsr_pkg::B_TAG_STEP] &&
         i_tag_res == spsr_pkg::RES_BY_CMD) || // RL12
        (tag_clk_rise && i_tag_res == spsr_pkg::RES_EXT_CLK); // RL17
    end
  end

  // RT offline tracking and return to service
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rt_offline <= 1'b0;
      o_terminal_back_online <= 1'b0;
    end else begin
      o_terminal_back_online <= 1'b0;
      if (o_rt_offline &&
          (i_selftest_done || cmd[spsr_pkg::B_BACK_ONLINE])) begin
        o_rt_offline <= 1'b0; // RL5 RL6
        o_terminal_back_online <= 1'b1; // RL5 RL6
      end else if (i_offline_on_selftest && rt_st_cmd_r) begin
        o_rt_offline <= 1'b1;
      end
    end
  end

  // Initiate-self-test mode command; no source here, held low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rt_st_cmd_r <= 1'b0;
    end else begin
      rt_st_cmd_r <= 1'b0;
    end
  end

  // Assertions
  // Strobe high for exactly one cycle
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence

  // Command bit written once, not repeated next cycle
  sequence s_lone(ev);
    ev ##1 !ev;
  endsequence

  // No command strobe active apart from tag step and back online
  sequence s_quiet;
    !o_soft_reset_cmd && !o_controller_monitor_go && !o_irq_status_clear &&
    !o_tag_counter_clear && !o_halt_end_of_frame &&
    !o_halt_end_of_message && !o_monitor_stop &&
    !o_protocol_selftest_go && !o_ram_selftest_go &&
    !o_clear_selftest_result;
  endsequence

  rd_ptr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL1
    rd_hit && !(is_bc && i_enhanced_bc) |=> o_rdata == $past(i_stack_ptr))
    else $error("stack pointer readback wrong");

  rd_instr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL2
    rd_hit && is_bc && i_enhanced_bc |=> o_rdata == $past(i_instr_ptr))
    else $error("instruction pointer readback wrong");

  soft_rst_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL16
    s_lone(wr_hit && i_wdata[0]) |-> s_pulse(o_soft_reset_cmd))
    else $error("soft reset not one pulse");

  irq_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL14
    o_irq_status_clear |-> $past(wr_hit && i_wdata[2]))
    else $error("irq clear without command");

  tag_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL12
    wr_hit && i_wdata[4] && i_tag_res != 3'h6 && !tag_clk_rise
    |=> !o_tag_counter_step)
    else $error("tag step at wrong resolution");

  tag_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL13
    wr_hit && i_wdata[3] |=> o_tag_counter_clear)
    else $error("tag clear missed");

  ram_go_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL8
    o_ram_selftest_go == $past(wr_hit && i_wdata[9]))
    else $error("ram self-test strobe wrong");

  proto_go_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL9
    o_protocol_selftest_go == $past(wr_hit && i_wdata[7]))
    else $error("protocol self-test strobe wrong");

  clr_res_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL7
    o_clear_selftest_result == $past(wr_hit && i_wdata[10]))
    else $error("clear result strobe wrong");

  online_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL6
    o_rt_offline && wr_hit && i_wdata[11] |=> o_terminal_back_online
    ##1 !o_terminal_back_online)
    else $error("back online pulse wrong");

  go_bc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL15
    s_lone(wr_hit && i_wdata[1]) and is_bc[*2]
    |-> s_pulse(o_controller_monitor_go))
    else $error("controller start pulse wrong");

  go_rt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL15
    wr_hit && i_wdata[1] && !is_bc && !is_mt
    |=> !o_controller_monitor_go)
    else $error("start strobe outside controller or monitor");

  go_src_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL15
    o_controller_monitor_go |-> $past(wr_hit && i_wdata[1]))
    else $error("start strobe without command");

  halt_fr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL11
    wr_hit && i_wdata[5] && is_bc |=> o_halt_end_of_frame)
    else $error("frame halt missed");

  halt_fr_mt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL11
    wr_hit && i_wdata[5] && !is_bc |=> !o_halt_end_of_frame)
    else $error("frame halt outside controller mode");

  halt_msg_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL10
    wr_hit && i_wdata[6] && is_bc |=> o_halt_end_of_message
    && !o_monitor_stop)
    else $error("message halt wrong");

  mon_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL10
    wr_hit && i_wdata[6] && is_mt |=> o_monitor_stop
    && !o_halt_end_of_message)
    else $error("monitor stop wrong");

  irq_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL18
    s_lone(wr_hit && i_wdata[2]) |-> s_pulse(o_irq_status_clear))
    else $error("irq clear not one pulse");

  tag_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL12
    wr_hit && i_wdata[4] && i_tag_res == spsr_pkg::RES_BY_CMD
    |=> o_tag_counter_step)
    else $error("tag step by command missed");

  tag_ext_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL17
    tag_clk_rise && i_tag_res == spsr_pkg::RES_EXT_CLK
    |=> o_tag_counter_step)
    else $error("tag step by external clock missed");

  tag_src_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL17
    o_tag_counter_step |->
    $past((wr_hit && i_wdata[4] && i_tag_res == spsr_pkg::RES_BY_CMD) ||
          (tag_clk_rise && i_tag_res == spsr_pkg::RES_EXT_CLK)))
    else $error("tag step without cause");

  tag_clr_src_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL13
    o_tag_counter_clear == $past(wr_hit && i_wdata[3]))
    else $error("tag clear strobe wrong");

  soft_src_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL19
    o_soft_reset_cmd |-> $past(wr_hit && i_wdata[0]))
    else $error("soft reset without command");

  zero_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL19
    wr_hit && i_wdata == 16'h0000 |=> s_quiet)
    else $error("zero write raised a strobe");

  miss_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL20
    !wr_hit |=> s_quiet)
    else $error("strobe without shared-address write");

  rvalid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL20
    o_rvalid == $past(rd_hit))
    else $error("read valid wrong");

  rd_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL3
    !rd_hit |=> $stable(o_rdata))
    else $error("readback changed without read");

  wr_no_rd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL20
    wr_hit && !rd_hit |=> !o_rvalid)
    else $error("write produced read valid");

  rd_no_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL20
    rd_hit && !wr_hit |=> s_quiet)
    else $error("read produced a strobe");

  online_st_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL5
    o_rt_offline && i_selftest_done |=> s_pulse(o_terminal_back_online))
    else $error("restart after self-test missed");

  online_src_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL5
    o_terminal_back_online |-> $past(o_rt_offline) && !o_rt_offline)
    else $error("back online while not offline");

  rst_rd_a: assert property (@(posedge i_clk) // RL3
    !$past(i_rst_n) |-> o_rdata == spsr_pkg::PTR_RESET && !o_rvalid)
    else $error("readback not cleared by reset");

  rst_strobe_a: assert property (@(posedge i_clk) // RL19
    !$past(i_rst_n) |-> !o_tag_counter_step && !o_rt_offline
    && !o_terminal_back_online)
    else $error("tag or online state not cleared by reset");
endmodule

// ===== design/spsr_pkg.sv
// Purpose: Constants for the stack pointer readback and command strobe block
// Assumes: 16-bit host data, word offsets as printed
// Notes: Offset is a register index on the host bus
package spsr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] SHARED_OFFSET = 16'h0003;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  // Command bit positions
  localparam int B_SOFT_RESET = 0;
  localparam int B_CTRL_MON_GO = 1;
  localparam int B_IRQ_CLEAR = 2;
  localparam int B_TAG_CLEAR = 3;
  localparam int B_TAG_STEP = 4;
  localparam int B_HALT_FRAME = 5;
  localparam int B_HALT_MSG = 6;
  localparam int B_PROTO_TEST = 7;
  localparam int B_RSVD_8 = 8;
  localparam int B_RAM_TEST = 9;
  localparam int B_CLR_RESULT = 10;
  localparam int B_BACK_ONLINE = 11;
  localparam int B_RSVD_LO = 12;
  localparam int B_RSVD_HI = 15;
  // Time tag resolution field codes
  localparam logic [2:0] RES_BY_CMD = 3'h6;
  localparam logic [2:0] RES_EXT_CLK = 3'h7;
  // Operating mode codes
  localparam logic [1:0] MODE_BC = 2'h0;
  localparam logic [1:0] MODE_RT = 2'h1;
  localparam logic [1:0] MODE_MT = 2'h2;
endpackage

// ===== design/spsr_sync.sv
// Purpose: Two-stage synchroniser with rising edge pulse
// Assumes: Input asynchronous to i_clk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module spsr_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);
  logic meta_r;
  logic prev_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      o_level <= 1'b0;
      prev_r <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      meta_r <= i_async;
      o_level <= meta_r;
      prev_r <= o_level;
      o_rise <= o_level & ~prev_r;
    end
  end
endmodule

// ===== verif/spsr_host.sv
// Purpose: Host processor model on the parallel bus
// Assumes: One-cycle read and write strobes
// Notes: Released lines show the inverse of the last value
`timescale 1ns/1ps
module spsr_host (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [15:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  initial begin
    o_addr = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d & 16'h0eff;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(output logic [15:0] q);
    @(posedge i_clk);
    o_addr <= spsr_pkg::SHARED_OFFSET;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~spsr_pkg::SHARED_OFFSET;
    @(negedge i_clk);
    q = i_rdata;
  endtask
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the shared-address register logic
// Assumes: Strobes appear one cycle after the write edge
// Notes: Seen vector packs strobes by command bit, monitor stop at 12
`timescale 1ns/1ps
module testbench;
  logic i_clk, i_rst_n, i_wr, i_rd, i_enhanced_bc, i_tag_clk;
  logic i_irq_read_clear, i_offline_on_selftest, i_selftest_done;
  logic [15:0] i_addr, i_wdata, i_stack_ptr, i_instr_ptr, o_rdata;
  logic [1:0] i_mode;
  logic [2:0] i_tag_res;
  logic o_rvalid, o_soft_reset_cmd, o_controller_monitor_go;
  logic o_irq_status_clear, o_tag_counter_clear, o_tag_counter_step;
  logic o_halt_end_of_frame, o_halt_end_of_message, o_monitor_stop;
  logic o_protocol_selftest_go, o_ram_selftest_go, o_rt_offline;
  logic o_clear_selftest_result, o_terminal_back_online;
  logic [15:0] q;
  int n_errors = 0;
  int comparisons = 0;
  wire logic [15:0] seen = {3'h0, o_monitor_stop, o_terminal_back_online,
    o_clear_selftest_result, o_ram_selftest_go, 1'b0,
    o_protocol_selftest_go, o_halt_end_of_message, o_halt_end_of_frame,
    o_tag_counter_step, o_tag_counter_clear, o_irq_status_clear,
    o_controller_monitor_go, o_soft_reset_cmd};
  spsr_regs DUT (.i_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata,
    .i_mode, .i_enhanced_bc, .i_stack_ptr, .i_instr_ptr, .i_tag_res,
    .i_irq_read_clear, .i_offline_on_selftest, .i_selftest_done,
    .i_tag_clk, .o_rdata, .o_rvalid, .o_soft_reset_cmd,
    .o_controller_monitor_go, .o_irq_status_clear, .o_tag_counter_clear,
    .o_tag_counter_step, .o_halt_end_of_frame, .o_halt_end_of_message,
    .o_monitor_stop, .o_protocol_selftest_go, .o_ram_selftest_go,
    .o_clear_selftest_result, .o_terminal_back_online, .o_rt_offline);
  spsr_host host (.i_clk, .i_rdata(o_rdata), .o_addr(i_addr),
    .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
  task automatic wrap_up;
    $display("Errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cmd(input logic [15:0] d, input logic [15:0] e);
    host.wr(spsr_pkg::SHARED_OFFSET, d);
    @(negedge i_clk);
    chk(seen, e);
    @(negedge i_clk);
    chk(seen, 16'h0000);
  endtask
  task automatic cfg(input logic [1:0] m, input logic n, input logic [2:0] r);
    @(posedge i_clk);
    i_mode <= m;
    i_enhanced_bc <= n;
    i_tag_res <= r;
  endtask
  task automatic t_bc_cmds;
    logic [15:0] m;
    cfg(spsr_pkg::MODE_BC, 1'b0, spsr_pkg::RES_BY_CMD);
    for (int b = 0; b < 11; b++) begin
      m = 16'h0001 << b;
      if (b != spsr_pkg::B_RSVD_8) begin
        cmd(m, m);
      end
    end
    cmd(16'h0800, 16'h0000);
    cmd(16'hf100, 16'h0000);
  endtask
  task automatic t_mt;
    cfg(spsr_pkg::MODE_MT, 1'b0, 3'h0);
    cmd(16'h0040, 16'h1000);
    cmd(16'h0020, 16'h0000);
    cmd(16'h0002, 16'h0002);
    cmd(16'h0010, 16'h0000);
  endtask
  task automatic t_read;
    cfg(spsr_pkg::MODE_RT, 1'b0, spsr_pkg::RES_BY_CMD);
    i_stack_ptr <= 16'h1234;
    i_instr_ptr <= 16'habcd;
    host.rd(q);
    chk(q, 16'h1234);
    chk({15'h0000, o_rvalid}, 16'h0001);
    chk({15'h0000, o_rt_offline}, 16'h0000);
    chk(seen, 16'h0000);
    cmd(16'h0004, 16'h0004);
    chk(o_rdata, 16'h1234);
    cfg(spsr_pkg::MODE_BC, 1'b1, spsr_pkg::RES_BY_CMD);
    host.rd(q);
    chk(q, 16'habcd);
    host.wr(16'h0004, 16'h0001);
    @(negedge i_clk);
    chk(seen, 16'h0000);
  endtask
  task automatic t_ext;
    int hits;
    hits = 0;
    cfg(spsr_pkg::MODE_BC, 1'b0, spsr_pkg::RES_EXT_CLK);
    i_tag_clk <= 1'b1;
    repeat (8) begin
      @(negedge i_clk);
      if (o_tag_counter_step === 1'b1) hits++;
    end
    @(posedge i_clk);
    i_tag_clk <= 1'b0;
    chk(hits[15:0], 16'h0001);
    cmd(16'h0010, 16'h0000);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    i_rst_n = 1'b0;
    i_mode = 2'h0;
    i_enhanced_bc = 1'b0;
    i_tag_res = 3'h0;
    i_tag_clk = 1'b0;
    i_stack_ptr = 16'h5a5a;
    i_instr_ptr = 16'ha5a5;
    i_irq_read_clear = 1'b0;
    i_offline_on_selftest = 1'b0;
    i_selftest_done = 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk(o_rdata, spsr_pkg::PTR_RESET);
    chk(seen, 16'h0000);
    t_bc_cmds;
    t_mt;
    t_read;
    t_ext;
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    wrap_up;
  end
endmodule
